//--- pkg/char_lcd_pkg.sv
// constants and carrier types for the character display glyph/cursor/host port slice
// assumes a single 100 MHz clock and a host bus sampled synchronously to it
package char_lcd_pkg;
	localparam int CLK_MHZ = 100;
	localparam int EXEC_TIME_NS = 37000;
	localparam int BUSY_CYCLES = (EXEC_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int BUSY_W = $clog2(BUSY_CYCLES + 1);
	localparam int SCAN_DIV_DEFAULT = 16;
	localparam int TEXT_DEPTH = 16;
	localparam int GLYPH_COUNT = 4;
	localparam int GLYPH_ROWS = 8;
	localparam int GLYPH_COLS = 5;
	localparam int GLYPH_DEPTH = GLYPH_COUNT * GLYPH_ROWS;
	localparam int SEG_COUNT = 40;
	localparam int COM_COUNT = 16;
	localparam int CHARS_PER_HALF = 8;
	localparam int AC_W = 7;
	localparam logic [2:0] CURSOR_ROW = 3'h7;
	localparam logic [2:0] LAST_COL = 3'h4;
	localparam logic [5:0] LAST_BIT = 6'h27;
	localparam logic [3:0] LAST_COM = 4'hf;
	localparam logic [3:0] GLYPH_HIGH_CODE = 4'h0;
	localparam int SET_TEXT_ADDR_BIT = 7;
	localparam int SET_GLYPH_ADDR_BIT = 6;
	localparam int BLINK_W = 5;
	localparam logic [COM_COUNT-1:0] COM_ONE = 16'h0001;
	localparam logic [3:0] NIBBLE_ZERO = 4'h0;

	typedef struct packed {
		logic strobe;
		logic target;
		logic rd;
		logic [7:0] data;
	} host_req_t;

	typedef struct packed {
		logic [7:0] data;
		logic oe;
		logic busy;
	} host_rsp_t;

	typedef struct packed {
		logic [TEXT_DEPTH-1:0][7:0] text;
		logic [GLYPH_DEPTH-1:0][GLYPH_COLS-1:0] glyph;
		logic [AC_W-1:0] ac;
		logic ac_glyph;
		logic nibble_phase;
		logic [3:0] hold_nibble;
		logic [7:0] rd_data;
		logic busy;
		logic [BUSY_W-1:0] busy_cnt;
		logic [7:0] div_cnt;
		logic [5:0] bit_cnt;
		logic [2:0] char_idx;
		logic [2:0] col;
		logic [3:0] com_idx;
		logic [3:0] disp_com;
		logic [SEG_COUNT-1:0] shift;
		logic [SEG_COUNT-1:0] seg_latch;
		logic [BLINK_W-1:0] blink_cnt;
	} state_t;
endpackage

//--- design/char_lcd_glyph_cursor_host_port.sv
// display controller slice: user glyph store, cursor/blink overlay, 40-bit segment
// shift and latch with 16 commons, and the 4/8-bit host port with busy flag.
// assumes host strobes are one-cycle pulses synchronous to MCLK.
//
// Contract
// - four user glyphs, five by eight dots
// - codes 00h-03h show user glyphs
// - code bits 1:0 form glyph address 4:3
// - glyph address 2:0 selects pattern line
// - eighth line ORed with cursor
// - glyph words store bits 4:0 only
// - high nibble zero selects glyph, aliasing
// - one bit lights dot, zero leaves off
// - refresh reads independent of host access
// - sixteen commons, forty segments
// - shift 40 bits, then latch
// - cursor at address counter text position
// - glyph address still places cursor
// - one 8-bit or two 4-bit transfers
// - 4-bit mode uses upper lines only
// - high nibble first, pair completes access
// - status read returned over two nibbles
// - busy high while operating, else low
// - width bit set means 8-bit
// - accesses qualified by select and direction
`timescale 1ns/1ps
`default_nettype none

module char_lcd_glyph_cursor_host_port
#(
	parameter int SCAN_DIV = char_lcd_pkg::SCAN_DIV_DEFAULT
)
(
	input wire logic MCLK,
	input wire logic RST_N,
	input wire char_lcd_pkg::host_req_t HOST_REQ,
	output char_lcd_pkg::host_rsp_t HOST_RSP,
	input wire logic BUS_WIDTH_SELECT,
	input wire logic CURSOR_ON,
	input wire logic BLINK_ON,
	output logic [char_lcd_pkg::COM_COUNT-1:0] COM,
	output logic [char_lcd_pkg::SEG_COUNT-1:0] SEG
);
	import char_lcd_pkg::*;

	state_t st;
	state_t next_st;

	logic [3:0] text_addr;
	logic [7:0] code;
	logic [2:0] row;
	logic use_glyph;
	logic [GLYPH_COLS-1:0] glyph_row;
	logic [GLYPH_COLS-1:0] font_row;
	logic [GLYPH_COLS-1:0] pattern;
	logic cursor_here;
	logic dot;
	logic tick;
	logic half_only;
	logic byte_done;
	logic [7:0] byte_in;
	logic [7:0] byte_out;

	// stand-in for the fixed font; its real contents live outside this slice
	function automatic logic [GLYPH_COLS-1:0] fixed_font_rom(input logic [7:0] c, input logic [2:0] r);
		fixed_font_rom = c[GLYPH_COLS-1:0] ^ {2'h0, r};
	endfunction

	// refresh path: reads the stores through its own port every cycle,
	// host writes land on the registered copy and never stall the scan
	always_comb
	begin
		text_addr = {st.com_idx[3], st.char_idx};
		code = st.text[text_addr];
		row = st.com_idx[2:0];
		use_glyph = code[7:4] == GLYPH_HIGH_CODE;
		glyph_row = st.glyph[{code[1:0], row}];
		font_row = fixed_font_rom(code, row);
		pattern = use_glyph ? glyph_row : font_row;
		dot = pattern[LAST_COL - st.col];
		// only the low counter bits place the cursor, glyph addresses included
		cursor_here = text_addr == st.ac[3:0];
		if (CURSOR_ON && cursor_here && row == CURSOR_ROW)
		begin
			dot = 1'b1;
		end
		if (BLINK_ON && cursor_here && st.blink_cnt[BLINK_W-1])
		begin
			dot = 1'b1;
		end
	end

	assign tick = st.div_cnt == 8'(SCAN_DIV - 1);
	assign half_only = !BUS_WIDTH_SELECT;

	// host byte assembly: in 4-bit mode only the upper lines carry data
	always_comb
	begin
		byte_done = 1'b0;
		byte_in = HOST_REQ.data;
		if (HOST_REQ.strobe)
		begin
			if (half_only)
			begin
				byte_done = st.nibble_phase;
				byte_in = {st.hold_nibble, HOST_REQ.data[7:4]};
			end
			else
			begin
				byte_done = 1'b1;
			end
		end
	end

	always_comb
	begin
		if (!HOST_REQ.target)
		begin
			byte_out = {st.busy, st.ac};
		end
		else if (st.ac_glyph)
		begin
			byte_out = {3'h0, st.glyph[st.ac[4:0]]};
		end
		else
		begin
			byte_out = st.text[st.ac[3:0]];
		end
	end

	always_comb
	begin
		next_st = st;
		// host side
		if (HOST_REQ.strobe)
		begin
			if (half_only)
			begin
				next_st.nibble_phase = !st.nibble_phase;
				if (!st.nibble_phase)
				begin
					next_st.hold_nibble = HOST_REQ.rd ? byte_out[3:0] : HOST_REQ.data[7:4];
				end
				if (HOST_REQ.rd)
				begin
					next_st.rd_data = st.nibble_phase ? {st.hold_nibble, NIBBLE_ZERO} : {byte_out[7:4], NIBBLE_ZERO};
				end
			end
			else if (HOST_REQ.rd)
			begin
				next_st.rd_data = byte_out;
			end
		end
		if (!half_only)
		begin
			next_st.nibble_phase = 1'b0;
		end
		// the count runs on through status reads and lone nibbles; a completing write or data read reloads it below
		if (st.busy)
		begin
			next_st.busy_cnt = st.busy_cnt - BUSY_W'(1);
			if (st.busy_cnt == BUSY_W'(1))
			begin
				next_st.busy = 1'b0;
			end
		end
		if (byte_done)
		begin
			if (HOST_REQ.target)
			begin
				// data access: write or read, then step the counter
				if (!HOST_REQ.rd)
				begin
					if (st.ac_glyph)
					begin
						next_st.glyph[st.ac[4:0]] = byte_in[GLYPH_COLS-1:0];
					end
					else
					begin
						next_st.text[st.ac[3:0]] = byte_in;
					end
				end
				next_st.ac = st.ac + 7'h01;
				next_st.busy = 1'b1;
				next_st.busy_cnt = BUSY_W'(BUSY_CYCLES);
			end
			else if (!HOST_REQ.rd)
			begin
				// only the address instructions matter to this slice
				if (byte_in[SET_TEXT_ADDR_BIT])
				begin
					next_st.ac = byte_in[AC_W-1:0];
					next_st.ac_glyph = 1'b0;
				end
				else if (byte_in[SET_GLYPH_ADDR_BIT])
				begin
					next_st.ac = {2'h0, byte_in[4:0]};
					next_st.ac_glyph = 1'b1;
				end
				next_st.busy = 1'b1;
				next_st.busy_cnt = BUSY_W'(BUSY_CYCLES);
			end
		end
		// refresh side
		next_st.div_cnt = tick ? 8'h00 : st.div_cnt + 8'h01;
		if (tick)
		begin
			next_st.shift = {st.shift[SEG_COUNT-2:0], dot};
			next_st.bit_cnt = st.bit_cnt + 6'h01;
			next_st.col = st.col + 3'h1;
			if (st.col == LAST_COL)
			begin
				next_st.col = 3'h0;
				next_st.char_idx = st.char_idx + 3'h1;
			end
			if (st.bit_cnt == LAST_BIT)
			begin
				// latch only once the whole row has shifted in, so segments never tear
				next_st.seg_latch = {st.shift[SEG_COUNT-2:0], dot};
				next_st.disp_com = st.com_idx;
				next_st.bit_cnt = 6'h00;
				next_st.col = 3'h0;
				next_st.char_idx = 3'h0;
				next_st.com_idx = st.com_idx + 4'h1;
				if (st.com_idx == LAST_COM)
				begin
					next_st.blink_cnt = st.blink_cnt + BLINK_W'(1);
				end
			end
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign COM = COM_ONE << st.disp_com;
	assign SEG = st.seg_latch;
	assign HOST_RSP.data = st.rd_data;
	assign HOST_RSP.oe = HOST_REQ.rd;
	assign HOST_RSP.busy = st.busy;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	busy_after_write_a: assert property (byte_done && !HOST_REQ.rd |=> st.busy && st.busy_cnt == BUSY_W'(BUSY_CYCLES))
		else $error("busy not raised for full execution time");
	busy_clears_a: assert property (st.busy && st.busy_cnt == BUSY_W'(1) && !byte_done |=> !st.busy)
		else $error("busy did not clear at end of count");
	latch_after_shift_a: assert property ($changed(st.seg_latch) |-> $past(st.bit_cnt) == LAST_BIT && $past(tick))
		else $error("segment latch moved before 40 bits shifted");
	com_onehot_a: assert property ($onehot(COM))
		else $error("commons not one-hot");
	nibble_pair_a: assert property (half_only && HOST_REQ.strobe && !st.nibble_phase |-> !byte_done)
		else $error("byte completed on first nibble");
	wide_no_phase_a: assert property (BUS_WIDTH_SELECT |=> !st.nibble_phase)
		else $error("nibble phase left set in 8-bit mode");
	cursor_row_or_a: assert property (CURSOR_ON && cursor_here && row == CURSOR_ROW |-> dot)
		else $error("cursor row dot not lit");
	glyph_select_a: assert property (code[7:4] == GLYPH_HIGH_CODE |-> pattern == st.glyph[{code[1:0], row}])
		else $error("glyph pattern not selected");
	status_nibbles_a: assert property (half_only && HOST_REQ.strobe && HOST_REQ.rd && !HOST_REQ.target && !st.nibble_phase
		##1 !HOST_REQ.strobe ##1 HOST_REQ.strobe && HOST_REQ.rd |=> st.rd_data[7:4] == $past(st.hold_nibble))
		else $error("second status nibble wrong");
	lower_lines_zero_a: assert property (half_only && $past(HOST_REQ.strobe && HOST_REQ.rd) |-> st.rd_data[3:0] == NIBBLE_ZERO)
		else $error("lower lines carry data in 4-bit mode");
endmodule

`default_nettype wire

//--- testbench/host_model.sv
// host processor model for the parallel port of the display slice
// assumes the bench calls its tasks; requests launch on the falling edge
`timescale 1ns/1ps
`default_nettype none

module host_model
(
	input wire logic mclk,
	output var char_lcd_pkg::host_req_t req,
	input wire char_lcd_pkg::host_rsp_t rsp
);
	import char_lcd_pkg::*;

	initial req = '0;

	task automatic xfer(input logic t, input logic r, input logic [7:0] d, output logic [7:0] q);
		@(negedge mclk);
		req <= '{strobe: 1'b1, target: t, rd: r, data: d};
		@(negedge mclk);
		q = rsp.data;
		// released lines show the inverse, not a stale copy
		req <= '{strobe: 1'b0, target: t, rd: r, data: ~d};
	endtask

	task automatic acc(input logic w8, input logic t, input logic r, input logic [7:0] d, output logic [7:0] q);
		logic [7:0] hi;
		logic [7:0] lo;
		if (w8)
		begin
			xfer(t, r, d, q);
		end
		else
		begin
			// lower lines carry junk that must be ignored
			xfer(t, r, {d[7:4], ~d[3:0]}, hi);
			xfer(t, r, {d[3:0], ~d[7:4]}, lo);
			q = {hi[7:4], lo[7:4]};
		end
	endtask

	task automatic idle(input logic w8);
		logic [7:0] s;
		s = 8'h80;
		for (int i = 0; i < 3000 && s[7]; i++)
		begin
			acc(w8, 1'b0, 1'b1, 8'h00, s);
		end
	endtask
endmodule

`default_nettype wire

//--- testbench/char_lcd_glyph_cursor_host_port_tb.sv
// self-checking bench for the display slice host port and busy flag
// assumes host_model drives the request side
`timescale 1ns/1ps
`default_nettype none

module char_lcd_glyph_cursor_host_port_tb;
	import char_lcd_pkg::*;

	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic w8 = 1'b1;
	logic cursor_on = 1'b0;
	logic blink_on = 1'b0;
	host_req_t req;
	host_rsp_t rsp;
	logic [15:0] com;
	logic [39:0] seg;
	logic [7:0] q;
	int err_count = 0;
	int comparisons = 0;

	always #5 mclk = ~mclk;

	char_lcd_glyph_cursor_host_port #(.SCAN_DIV(2)) char_lcd_glyph_cursor_host_port_inst (.MCLK(mclk),
		.RST_N(rst_n), .HOST_REQ(req), .HOST_RSP(rsp), .BUS_WIDTH_SELECT(w8), .CURSOR_ON(cursor_on),
		.BLINK_ON(blink_on), .COM(com), .SEG(seg));
	host_model host_model_inst (.mclk(mclk), .req(req), .rsp(rsp));

	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wrap_up();
		if (err_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic t_reset();
		chk("com", 40'(COM_ONE), 40'(com));
		chk("seg", 40'h0, seg);
		chk("busy", 40'h0, 40'(rsp.busy));
	endtask

	task automatic t_busy();
		int n;
		n = 0;
		host_model_inst.acc(1'b1, 1'b0, 1'b0, 8'h85, q);
		host_model_inst.acc(1'b1, 1'b0, 1'b1, 8'h00, q);
		chk("status", 40'h85, 40'(q));
		while (rsp.busy === 1'b1 && n < 5000)
		begin
			@(negedge mclk);
			n++;
		end
		// two cycles of the span went by in the status read
		chk("busy_len", 40'(BUSY_CYCLES - 2), 40'(n));
	endtask

	task automatic t_mem(input logic w, input logic [7:0] set, input logic [7:0] d, input logic [7:0] e);
		@(negedge mclk);
		w8 = w;
		host_model_inst.acc(w, 1'b0, 1'b0, set, q);
		host_model_inst.idle(w);
		host_model_inst.acc(w, 1'b1, 1'b0, d, q);
		host_model_inst.idle(w);
		host_model_inst.acc(w, 1'b0, 1'b0, set, q);
		host_model_inst.idle(w);
		host_model_inst.acc(w, 1'b1, 1'b1, 8'h00, q);
		chk("read", 40'(e), 40'(q));
		host_model_inst.idle(w);
		host_model_inst.acc(w, 1'b0, 1'b1, 8'h00, q);
		chk("status", 40'((set & 8'h1f) + 8'h01), 40'(q));
	endtask

	// glyph 0 line 7 is never written, so only the cursor can light char 7 on row 7
	task automatic t_cursor();
		int n;
		n = 0;
		@(negedge mclk);
		cursor_on = 1'b1;
		while (com !== 16'h0002 && n < 3000)
		begin
			@(negedge mclk);
			n++;
		end
		while (com !== 16'h0080 && n < 3000)
		begin
			@(negedge mclk);
			n++;
		end
		chk("com_row", 40'h80, 40'(com));
		chk("cursor", 40'h1f, 40'(seg[4:0]));
	endtask

	initial
	begin
		repeat (20) @(negedge mclk);
		t_reset();
		rst_n = 1'b1;
		t_busy();
		t_mem(1'b1, 8'h83, 8'ha5, 8'ha5);
		t_mem(1'b0, 8'h46, 8'hff, 8'h1f);
		t_cursor();
		wrap_up();
	end

	initial
	begin
		#600000;
		err_count++;
		wrap_up();
	end
endmodule

`default_nettype wire
